//--- rtl/owr_regs.vh
// Constants for the one-wire reference programming receiver.
// Assumes a 20 MHz clock; included by the receiver and the bench.
`ifndef OWR_REGS_VH
`define OWR_REGS_VH
`define OWR_CLK_MHZ          20
`define OWR_EOS_NS           2000
`define OWR_EOS_CYC          ((`OWR_EOS_NS * `OWR_CLK_MHZ + 999) / 1000)
`define OWR_ACK_PULSE_NS     512000
`define OWR_ACK_PULSE_CYC    ((`OWR_ACK_PULSE_NS * `OWR_CLK_MHZ) / 1000)
`define OWR_ACK_DELAY_NS     2000
`define OWR_ACK_DELAY_CYC    ((`OWR_ACK_DELAY_NS * `OWR_CLK_MHZ + 999) / 1000)
`define OWR_DEV_ADDR         8'h5A
`define OWR_LEVEL_RESET      5'h1F
`define OWR_FLAG_BIT         7
`define OWR_SUBADDR_HI       6
`define OWR_SUBADDR_LO       5
`define OWR_LEVEL_MSB        4
`define OWR_BYTE_BITS        5'h08
`define OWR_FRAME_BITS       5'h10
`endif

//--- rtl/owr_sync.v
// Three-stage input synchroniser for the shared control line.
// Assumes the pin is asynchronous to clock; output changes once stages two and three agree.
`timescale 1ns/1ps
module owr_sync (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Line
  input wire pinIn,
  output reg lineLevel
);
  reg stage1;
  reg stage2;
  reg stage3;

  // Stage one is read only by stage two to keep metastability contained
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage1    <= 1'b1;
      stage2    <= 1'b1;
      stage3    <= 1'b1;
      lineLevel <= 1'b1;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        lineLevel <= stage3;
    end
  end
endmodule

//--- rtl/owr_receiver.v
// One-wire reference level receiver: decodes address and data bytes, holds the level.
// Assumes an external pull-up on the line and a 20 MHz clock; line is open drain.
`timescale 1ns/1ps
`include "owr_regs.vh"
module owr_receiver #(
  parameter [7:0]  DEV_ADDR   = `OWR_DEV_ADDR,     // Arbitrary value, not a real part code
  parameter [19:0] ACK_CYCLES = `OWR_ACK_PULSE_CYC
) (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Control line, open drain
  input wire lineIn,
  output reg lineOut,
  output reg lineOe,
  // Reference level and status
  output reg [4:0] feedbackReference,
  output reg levelUpdated,
  output reg ackActive
);
  localparam [19:0] EOS_CYC   = `OWR_EOS_CYC;
  localparam [19:0] DLY_CYC   = `OWR_ACK_DELAY_CYC;
  localparam [19:0] CNT_MAX   = 20'hFFFFF;
  localparam [19:0] CNT_ONE   = 20'h00001;
  localparam [4:0]  BIT_MAX   = 5'h1F;
  localparam [2:0]  ST_IDLE   = 3'h0;
  localparam [2:0]  ST_BIT    = 3'h1;
  localparam [2:0]  ST_GAP    = 3'h2;
  localparam [2:0]  ST_WAIT   = 3'h3;
  localparam [2:0]  ST_ACK    = 3'h4;

  // Reset copy and line state
  reg        rstMeta;
  reg        rstn;
  wire       lineLevel;
  reg        linePrev;
  // Sequencing
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [19:0] highCnt;
  reg [19:0] lowCnt;
  reg [19:0] ackCnt;
  // Frame assembly: address in the upper byte, data in the lower
  reg [15:0] shiftReg;
  reg [4:0]  bitCount;

  // Decode terms, built from registered state only
  wire fallEdge  = linePrev & ~lineLevel;
  wire bitValue  = (highCnt > lowCnt);
  wire longLow   = ~lineLevel & (lowCnt >= EOS_CYC);
  wire byteDone  = (bitCount == `OWR_BYTE_BITS);
  wire frameFull = (bitCount == `OWR_FRAME_BITS);
  wire addrMatch = (shiftReg[15:8] == DEV_ADDR);
  wire subZero   = ~shiftReg[`OWR_SUBADDR_HI] & ~shiftReg[`OWR_SUBADDR_LO];
  wire frameGood = frameFull & addrMatch & subZero;
  wire ackWanted = frameGood & shiftReg[`OWR_FLAG_BIT];
  // Validity delay runs from the last seen falling edge; a released line ends it early
  wire decide    = (state == ST_WAIT) & ((lowCnt >= DLY_CYC) | lineLevel);

  // Reset release through two flops
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstn    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstn    <= rstMeta;
    end
  end

  owr_sync u_sync (
    .clock     (clock),
    .rstn      (rstn),
    .pinIn     (lineIn),
    .lineLevel (lineLevel)
  );

  // Previous line level; resets high like the idle line so no false edge follows reset
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      linePrev <= 1'b1;
    end else begin
      linePrev <= lineLevel;
    end
  end

  // Phase counters: restart at every falling edge and saturate instead of wrapping.
  // Limitation: a low phase of EOS_CYC or more reads as end of stream, so very
  // slow bit rates are taken as a cut frame and dropped.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      highCnt <= 20'h00000;
      lowCnt  <= 20'h00000;
    end else if (fallEdge) begin
      highCnt <= 20'h00000;
      lowCnt  <= CNT_ONE;
    end else if (lineLevel) begin
      if (highCnt != CNT_MAX) begin
        highCnt <= highCnt + CNT_ONE;
      end
    end else begin
      if (lowCnt != CNT_MAX) begin
        lowCnt <= lowCnt + CNT_ONE;
      end
    end
  end

  // Frame assembly: each falling edge in a byte closes one bit, MSB first.
  // The edge that opens a frame or the data byte closes nothing.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shiftReg <= 16'h0000;
      bitCount <= 5'h00;
    end else if ((state == ST_IDLE) && fallEdge) begin
      bitCount <= 5'h00;
    end else if ((state == ST_BIT) && fallEdge) begin
      shiftReg <= {shiftReg[14:0], bitValue};
      if (bitCount != BIT_MAX) begin
        bitCount <= bitCount + 5'h01;
      end
    end
  end

  // State register
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Next state: a long low closes a byte; after the second byte the frame is judged
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (fallEdge) begin
          next_state = ST_BIT;
        end
      end
      ST_BIT: begin
        if (longLow) begin
          if (byteDone) begin
            next_state = ST_GAP;
          end else if (frameFull) begin
            next_state = ST_WAIT;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        // Start high between bytes; the next falling edge opens the data byte
        if (fallEdge) begin
          next_state = ST_BIT;
        end
      end
      ST_WAIT: begin
        if (decide) begin
          if (ackWanted) begin
            next_state = ST_ACK;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_ACK: begin
        if (ackCnt >= ACK_CYCLES) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Level register: only a whole, matching frame loads it
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      feedbackReference <= `OWR_LEVEL_RESET;
      levelUpdated      <= 1'b0;
    end else begin
      levelUpdated <= 1'b0;
      if (decide && frameGood) begin
        feedbackReference <= shiftReg[`OWR_LEVEL_MSB:0];
        levelUpdated      <= 1'b1;
      end
    end
  end

  // Acknowledge pull-down: open drain, so the data output stays low and only
  // the enable moves; the pulse lasts exactly ACK_CYCLES clocks
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ackCnt    <= 20'h00000;
      lineOe    <= 1'b0;
      ackActive <= 1'b0;
      lineOut   <= 1'b0;
    end else begin
      lineOut <= 1'b0;
      if (decide && ackWanted) begin
        lineOe    <= 1'b1;
        ackActive <= 1'b1;
        ackCnt    <= CNT_ONE;
      end else if (state == ST_ACK) begin
        if (ackCnt >= ACK_CYCLES) begin
          lineOe    <= 1'b0;
          ackActive <= 1'b0;
        end else begin
          ackCnt <= ackCnt + CNT_ONE;
        end
      end
    end
  end
endmodule

//--- sim/owr_monitor.sv
// Port checker for the reference receiver.
// Assumes one clock and the active-low reset.
`timescale 1ns/1ps
module owr_monitor #(parameter [19:0] ACK_CYCLES = 20'h02800) (
  input wire clock, input wire resetn, input wire lineIn, input wire lineOut,
  input wire lineOe, input wire [4:0] feedbackReference,
  input wire levelUpdated, input wire ackActive);
  reg [19:0] ackLen;
  // Pull-down length so far
  always @(posedge clock or negedge resetn)
    if (!resetn)
      ackLen <= 20'h00000;
    else
      ackLen <= ackActive ? ackLen + 20'h00001 : 20'h00000;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_pulldown_only: assert property (lineOut == 1'b0) else $error("line driven high");
  a_oe_is_ack: assert property (lineOe == ackActive) else $error("oe and ack differ");
  a_ack_max_len: assert property (ackLen <= ACK_CYCLES) else $error("ack too long");
  a_ack_after_load: assert property ($rose(ackActive) |-> levelUpdated)
    else $error("ack without load");
  a_load_one_pulse: assert property (levelUpdated |=> !levelUpdated) else $error("long load");
  a_level_needs_load: assert property ($changed(feedbackReference)
    |-> levelUpdated || $past(levelUpdated)) else $error("level changed alone");
  a_reset_full_scale: assert property ($rose(resetn) |-> feedbackReference == 5'h1F)
    else $error("reset level wrong");
  a_load_after_low: assert property (levelUpdated |-> !lineIn && !$past(lineIn, 2))
    else $error("load without end low");
  c_load: cover property (levelUpdated);
  c_ack: cover property ($rose(ackActive));
  c_ack_end: cover property ($fell(ackActive));
endmodule

//--- sim/owr_master.sv
// Master model: open-drain driver of the shared line, so it may ask for ack.
// Assumes the bench supplies the pull-up; the line is released outside frames.
`timescale 1ns/1ps
module owr_master (
  input wire clock,
  output reg mOe);
  initial mOe = 1'b0;
  // Bits MSB first, fall to fall; long phase twice the short, then end low
  task sendBits(input [7:0] v, input integer n, input integer t);
    integer i;
    for (i = 7; i > 7 - n; i = i - 1) begin
      mOe <= 1'b1;
      repeat (v[i] ? t : 2 * t) @(posedge clock);
      mOe <= 1'b0;
      repeat (v[i] ? 2 * t : t) @(posedge clock);
    end
    mOe <= 1'b1; // Last fall closes the byte
    repeat (60) @(posedge clock);
    mOe <= 1'b0;
  endtask
  // Start high, address byte, data byte {flag, 2'b00, level}
  task frame(input [7:0] a, input [7:0] d, input integer n, input integer t);
    repeat (60) @(posedge clock);
    sendBits(a, 8, t);
    repeat (60) @(posedge clock);
    sendBits(d, n, t);
  endtask
endmodule

//--- sim/owr_receiver_tb.sv
// Bench: frames from the master model, checks level and ack on the wire.
// Assumes the short ack parameter below and the designer's end-low timing.
`timescale 1ns/1ps
`include "owr_regs.vh"
module owr_receiver_tb;
  localparam [19:0] ACKC = 20'h00032;
  reg        clock = 1'b0;
  reg        resetn = 1'b0;
  wire       mOe, lineOe, lineOut, levelUpdated, ackActive;
  wire [4:0] feedbackReference;
  wire       line = ~(mOe | lineOe); // Pull-up unless a party pulls low
  integer    miscompares = 0;
  integer    samplesChecked = 0;
  reg  [4:0] expLevel = `OWR_LEVEL_RESET;
  integer    ackTotal = 0;
  integer    updTotal = 0;
  always #25 clock = ~clock;
  // Running counts of pull-down cycles and level loads
  always @(posedge clock) begin
    if (lineOe === 1'b1) ackTotal <= ackTotal + 1;
    if (levelUpdated === 1'b1) updTotal <= updTotal + 1;
  end
  owr_receiver #(.ACK_CYCLES(ACKC)) dut_u (.clock(clock), .resetn(resetn), .lineIn(line),
    .lineOut(lineOut), .lineOe(lineOe), .feedbackReference(feedbackReference),
    .levelUpdated(levelUpdated), .ackActive(ackActive));
  owr_master m_u (.clock(clock), .mOe(mOe));
  task chk(input [8*6-1:0] nm, input [19:0] e, input [19:0] g);
    begin
      samplesChecked = samplesChecked + 1;
      if (e !== g) begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // One frame; then the released line is sampled, a low means ack
  task xfer(input [7:0] a, input [7:0] d, input integer n, input integer t, input ok);
    integer a0, u0, na, nu;
    reg     expAck;
    begin
      a0 = ackTotal;
      u0 = updTotal;
      expAck = ok & d[`OWR_FLAG_BIT];
      m_u.frame(a, d, n, t);
      @(posedge clock);
      chk("ackbit", {19'h00000, ~expAck}, {19'h00000, line});
      repeat (400) @(posedge clock);
      na = ackTotal - a0;
      nu = updTotal - u0;
      if (ok) expLevel = d[4:0];
      chk("level", {15'h0000, expLevel}, {15'h0000, feedbackReference});
      chk("loads", {19'h00000, ok}, nu[19:0]);
      chk("acklen", expAck ? ACKC : 20'h00000, na[19:0]);
      $display("test done data %h bits %0d", d, 8 + n);
    end
  endtask
  task testDone;
    begin
      $display("checked %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Watchdog: seven frames need well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    miscompares = miscompares + 1;
    testDone;
  end
  // Tests: prompt and slow bit rates, ack, then refused frames
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (10) @(posedge clock);
    chk("reset", {15'h0000, `OWR_LEVEL_RESET}, {15'h0000, feedbackReference});
    xfer(`OWR_DEV_ADDR, 8'h00, 8, 5, 1'b1);
    xfer(`OWR_DEV_ADDR, 8'h15, 8, 12, 1'b1);
    xfer(`OWR_DEV_ADDR, 8'h8A, 8, 5, 1'b1);
    xfer(`OWR_DEV_ADDR ^ 8'h01, 8'h83, 8, 5, 1'b0);
    xfer(`OWR_DEV_ADDR, 8'hC3, 8, 5, 1'b0);
    xfer(`OWR_DEV_ADDR, 8'h83, 7, 5, 1'b0);
    resetn <= 1'b0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (10) @(posedge clock);
    expLevel = `OWR_LEVEL_RESET;
    chk("reset2", {15'h0000, `OWR_LEVEL_RESET}, {15'h0000, feedbackReference});
    $display("test done mid-run reset");
    xfer(`OWR_DEV_ADDR, 8'h91, 8, 5, 1'b1);
    testDone;
  end
endmodule
bind owr_receiver owr_monitor #(.ACK_CYCLES(ACK_CYCLES)) mon_u (.clock(clock),
  .resetn(resetn), .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe),
  .feedbackReference(feedbackReference), .levelUpdated(levelUpdated), .ackActive(ackActive));
